// ==== src/data_move_pkg.sv ====
/*
  Shared constants and carrier types for the data-move instruction executor.
  Assumes a single 40 MHz clock in which four cycles make one instruction cycle.
*/
package data_move_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned PHASES_PER_IC = 4;
  localparam logic [1:0]  PH_Q1         = 2'h0;
  localparam logic [1:0]  PH_Q2         = 2'h1;
  localparam logic [1:0]  PH_Q3         = 2'h2;
  localparam logic [1:0]  PH_Q4         = 2'h3;

  // ==========================================================================
  // instruction encodings
  // ==========================================================================
  localparam logic [7:0]  OP_PTR_LOAD_HI  = 8'hee;  // word 1 bits 15:8
  localparam logic [1:0]  OP_PTR_LOAD_PAD = 2'h0;   // word 1 bits 7:6
  localparam logic [1:0]  PTR_SEL_MAX     = 2'h2;
  localparam logic [3:0]  OP_SECOND_WORD  = 4'hf;   // prefix of any second word
  localparam logic [3:0]  OP_PTR_LOW_PAD  = 4'h0;   // second word bits 11:8
  localparam logic [5:0]  OP_REG_MOVE     = 6'h14;  // 0101 00
  localparam logic [3:0]  OP_COPY_FIRST   = 4'hc;

  // ==========================================================================
  // data-space addressing
  // ==========================================================================
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
  localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
  localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
  localparam logic [11:0] WORK_REG_ADDR   = 12'hff0;

  // ==========================================================================
  // software register map
  // ==========================================================================
  localparam logic [3:0]  REG_WORK     = 4'h0;
  localparam logic [3:0]  REG_BANK     = 4'h1;
  localparam logic [3:0]  REG_STATUS   = 4'h2;
  localparam logic [3:0]  REG_CTRL     = 4'h3;
  localparam logic [3:0]  REG_PTR_BASE = 4'h4;  // pointer n low at base+2n, high at base+2n+1
  localparam logic [3:0]  REG_PTR_LAST = 4'h9;
  localparam int unsigned ST_NEG_BIT   = 4;
  localparam int unsigned ST_ZERO_BIT  = 2;
  localparam int unsigned CTRL_EXT_BIT = 0;

  localparam logic [7:0]  RST_WORK     = 8'h00;
  localparam logic [3:0]  RST_BANK     = 4'h0;
  localparam logic [11:0] RST_PTR      = 12'h000;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PTR_LOW, SEQ_COPY_DEST} seq_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dmem_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0]        phase;
    logic              fetch;
    logic [15:0]       ir;
    logic              iv;
    seq_t              seq;
    logic [1:0]        ptr_sel;
    logic [7:0]        copy_data;
    logic [7:0]        work;
    logic [3:0]        bank;
    logic              neg;
    logic              zero;
    logic              ext_en;
    logic [2:0][11:0]  ptr;
    dmem_req_t         dmem;
    logic [7:0]        reg_rdata;
  } state_t;

endpackage : data_move_pkg

// ==== src/data_move_instruction_exec.sv ====
/*
  Decode and execute for the pointer-load, register-move and register-to-register
  copy instructions, plus the working, bank, status and pointer registers they touch.
  Assumes program memory presents a word with instr_valid in the Q1 cycle (fetch_q
  high), and data memory answers a read strobe with data one clock later.
*/
// The plain strobed port and the register addresses are this design's own decisions.
// Notes on behaviour
// - pointer load puts 12-bit literal into pointer 0..2 named by select.
// - pointer load is two words; first writes bits 11:8, second writes low byte.
// - register move goes to working register when d=0, back to file when d=1.
// - a=0 addresses access bank; a=1 uses bank select register.
// - extended set with a=0 and address up to 5Fh uses indexed offset.
// - register move decodes as 0101 00da plus address, one word, one cycle.
// - register move address covers 0..255 in a bank.
// - copy uses full 12-bit source and destination addresses.
// - copy accepts working register as source or destination.
// - copy reads source in cycle one, writes destination in Q4 of cycle two.
// - upper four bits of bank select always read zero.
`timescale 1ns/1ps

module data_move_instruction_exec (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic [15:0]             instr_word,
  input  wire logic                    instr_valid,
  input  wire logic                    instr_skip,
  input  wire logic [7:0]              dmem_rdata,
  input  wire data_move_pkg::reg_req_t reg_req,
  output      logic                    fetch_q,
  output      data_move_pkg::dmem_req_t dmem_req_q,
  output      logic [7:0]              reg_rdata_q
);
  import data_move_pkg::*;

  state_t q;
  state_t d;

  // ==========================================================================
  // address forming for the register move
  // ==========================================================================
  function automatic logic [11:0] move_addr(
    input logic [7:0]  f,
    input logic        a,
    input logic        ext,
    input logic [3:0]  bank,
    input logic [11:0] base
  );
    logic [11:0] r;
    r = {bank, f};
    if (!a) begin
      if (ext && f <= INDEXED_LIMIT) begin
        r = 12'(base + {4'h0, f});
      end else if (f < ACCESS_SPLIT) begin
        r = {ACCESS_LO_BANK, f};
      end else begin
        r = {ACCESS_HI_BANK, f};
      end
    end
    return r;
  endfunction : move_addr

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  logic is_ptr_first;
  logic is_move;
  logic is_copy_first;
  logic is_second;
  logic in_ptr_first;
  logic in_move;
  logic in_copy_first;
  logic in_second;
  logic [2:0] reg_ptr_idx;

  always_comb begin
    is_ptr_first  = q.iv && q.ir[15:8] == OP_PTR_LOAD_HI && q.ir[7:6] == OP_PTR_LOAD_PAD;
    is_move       = q.iv && q.ir[15:10] == OP_REG_MOVE;
    is_copy_first = q.iv && q.ir[15:12] == OP_COPY_FIRST;
    is_second     = q.iv && q.ir[15:12] == OP_SECOND_WORD;
    in_ptr_first  = instr_word[15:8] == OP_PTR_LOAD_HI && instr_word[7:6] == OP_PTR_LOAD_PAD;
    in_move       = instr_word[15:10] == OP_REG_MOVE;
    in_copy_first = instr_word[15:12] == OP_COPY_FIRST;
    in_second     = instr_word[15:12] == OP_SECOND_WORD;
    reg_ptr_idx   = 3'((reg_req.addr - REG_PTR_BASE) >> 1);
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic [7:0] val;
    logic [1:0] sel;
    val = 8'h00;
    sel = 2'h0;
    d = q;
    d.phase   = 2'(q.phase + 2'h1);
    d.fetch   = (q.phase == PH_Q4);
    d.dmem.rd = 1'b0;
    d.dmem.wr = 1'b0;

    // read data stands only in the cycle after the strobe
    d.reg_rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_WORK:   d.reg_rdata = q.work;
        REG_BANK:   d.reg_rdata = {4'h0, q.bank};
        REG_STATUS: begin
          d.reg_rdata[ST_NEG_BIT]  = q.neg;
          d.reg_rdata[ST_ZERO_BIT] = q.zero;
        end
        REG_CTRL:   d.reg_rdata[CTRL_EXT_BIT] = q.ext_en;
        default: begin
          if (reg_req.addr >= REG_PTR_BASE && reg_req.addr <= REG_PTR_LAST) begin
            d.reg_rdata = reg_req.addr[0] ? {4'h0, q.ptr[reg_ptr_idx][11:8]}
                                          : q.ptr[reg_ptr_idx][7:0];
          end
        end
      endcase
    end

    // software writes first so that the core, acting later, wins a collision
    if (reg_req.wr) begin
      case (reg_req.addr)
        REG_WORK:   d.work = reg_req.wdata;
        REG_BANK:   d.bank = reg_req.wdata[3:0];
        REG_STATUS: begin
          d.neg  = reg_req.wdata[ST_NEG_BIT];
          d.zero = reg_req.wdata[ST_ZERO_BIT];
        end
        REG_CTRL:   d.ext_en = reg_req.wdata[CTRL_EXT_BIT];
        default: begin
          if (reg_req.addr >= REG_PTR_BASE && reg_req.addr <= REG_PTR_LAST) begin
            if (reg_req.addr[0]) begin
              d.ptr[reg_ptr_idx][11:8] = reg_req.wdata[3:0];
            end else begin
              d.ptr[reg_ptr_idx][7:0] = reg_req.wdata;
            end
          end
        end
      endcase
    end

    case (q.phase)
      PH_Q1: begin
        // a skipped word becomes a no-operation cycle
        d.iv = instr_valid && !instr_skip;
        d.ir = d.iv ? instr_word : 16'h0000;
        if (d.iv && in_move) begin
          d.dmem.rd   = 1'b1;
          d.dmem.addr = move_addr(instr_word[7:0], instr_word[8], q.ext_en, q.bank, q.ptr[2]);
        end else if (d.iv && in_copy_first && instr_word[11:0] != WORK_REG_ADDR) begin
          d.dmem.rd   = 1'b1;
          d.dmem.addr = instr_word[11:0];
        end
        // a pending sequence dies if its second word does not follow
        if (!(d.iv && in_second)) begin
          d.seq = SEQ_IDLE;
        end
      end
      PH_Q3: begin
        if (is_move) begin
          val    = (q.dmem.addr == WORK_REG_ADDR) ? q.work : dmem_rdata;
          d.neg  = val[7];
          d.zero = (val == 8'h00);
          if (!q.ir[9]) begin
            d.work = val;
          end else begin
            d.dmem.wr    = 1'b1;
            d.dmem.wdata = val;
          end
          d.seq = SEQ_IDLE;
        end else if (is_copy_first) begin
          d.copy_data = (q.ir[11:0] == WORK_REG_ADDR) ? q.work : dmem_rdata;
          d.seq       = SEQ_COPY_DEST;
        end else if (is_ptr_first) begin
          sel = q.ir[5:4];
          if (sel <= PTR_SEL_MAX) begin
            d.ptr[sel][11:8] = q.ir[3:0];
            d.ptr_sel        = sel;
            d.seq            = SEQ_PTR_LOW;
          end else begin
            d.seq = SEQ_IDLE;
          end
        end else if (is_second) begin
          if (q.seq == SEQ_PTR_LOW && q.ir[11:8] == OP_PTR_LOW_PAD) begin
            d.ptr[q.ptr_sel][7:0] = q.ir[7:0];
          end else if (q.seq == SEQ_COPY_DEST) begin
            if (q.ir[11:0] == WORK_REG_ADDR) begin
              d.work = q.copy_data;
            end else begin
              d.dmem.wr    = 1'b1;
              d.dmem.addr  = q.ir[11:0];
              d.dmem.wdata = q.copy_data;
            end
          end
          // stray second word falls through as no-operation
          d.seq = SEQ_IDLE;
        end else begin
          d.seq = SEQ_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q           <= '0;
      q.phase     <= PH_Q4;
      q.seq       <= SEQ_IDLE;
      q.work      <= RST_WORK;
      q.bank      <= RST_BANK;
      q.ptr[0]    <= RST_PTR;
      q.ptr[1]    <= RST_PTR;
      q.ptr[2]    <= RST_PTR;
    end else begin
      q <= d;
    end
  end

  assign fetch_q     = q.fetch;
  assign dmem_req_q  = q.dmem;
  assign reg_rdata_q = q.reg_rdata;

endmodule : data_move_instruction_exec

// ==== tb/dm_assertions.sv ====
/*
  Port checker for the data-move executor.
  Assumes bind onto the executor top module, one clock, reset active high.
*/
`timescale 1ns/1ps
module dm_assertions (
  input wire logic                     clk_sys,
  input wire logic                     sys_rst,
  input wire logic [15:0]              instr_word,
  input wire logic                     instr_valid,
  input wire logic                     instr_skip,
  input wire logic [7:0]               dmem_rdata,
  input wire data_move_pkg::reg_req_t  reg_req,
  input wire logic                     fetch_q,
  input wire data_move_pkg::dmem_req_t dmem_req_q,
  input wire logic [7:0]               reg_rdata_q
);
  import data_move_pkg::*;
  // ==========================================================================
  // decode helpers
  // ==========================================================================
  logic go;
  logic mv;
  assign go = fetch_q && instr_valid && !instr_skip;
  // f0 excluded: it may alias the working register
  assign mv = go && instr_word[15:10] == OP_REG_MOVE && instr_word[7:0] != 8'hf0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence copy_first_s;
    go && instr_word[15:12] == OP_COPY_FIRST;
  endsequence
  sequence copy_pair_s;
    copy_first_s ##4 go && instr_word[15:12] == OP_SECOND_WORD && instr_word[11:0] != WORK_REG_ADDR;
  endsequence
  // ==========================================================================
  // properties
  // ==========================================================================
  fetch_period_a: assert property (fetch_q |=> !fetch_q [*3] ##1 fetch_q)
    else $error("fetch spacing wrong");
  move_read_a: assert property (mv && instr_word[8] |=>
    dmem_req_q.rd && dmem_req_q.addr[7:0] == $past(instr_word[7:0]))
    else $error("move read address wrong");
  access_bank_a: assert property (mv && !instr_word[8] && instr_word[7] |=>
    dmem_req_q.rd && dmem_req_q.addr == {ACCESS_HI_BANK, $past(instr_word[7:0])})
    else $error("access bank address wrong");
  move_back_a: assert property (mv && instr_word[9] |-> ##3
    dmem_req_q.wr && dmem_req_q.wdata == $past(dmem_rdata))
    else $error("move write-back wrong");
  move_to_w_a: assert property (mv && !instr_word[9] |-> ##3 !dmem_req_q.wr)
    else $error("move to work wrote memory");
  copy_src_a: assert property (copy_first_s ##0 instr_word[11:0] != WORK_REG_ADDR |=>
    dmem_req_q.rd && dmem_req_q.addr == $past(instr_word[11:0]))
    else $error("copy source read wrong");
  copy_dest_a: assert property (copy_pair_s |=> !dmem_req_q.rd ##2
    dmem_req_q.wr && dmem_req_q.addr == $past(instr_word[11:0], 3))
    else $error("copy destination write wrong");
  bank_high_a: assert property (reg_req.rd && reg_req.addr == REG_BANK |=> reg_rdata_q[7:4] == 4'h0)
    else $error("bank upper bits not zero");
endmodule : dm_assertions

bind data_move_instruction_exec dm_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .instr_word(instr_word), .instr_valid(instr_valid), .instr_skip(instr_skip), .dmem_rdata(dmem_rdata),
  .reg_req(reg_req), .fetch_q(fetch_q), .dmem_req_q(dmem_req_q), .reg_rdata_q(reg_rdata_q));

// ==== tb/prog_data_model.sv ====
/*
  Program and data memory model for the executor.
  Assumes the bench fills prog and mem directly; an empty slot stalls fetch.
*/
`timescale 1ns/1ps
module prog_data_model (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     fetch_q,
  input  wire data_move_pkg::dmem_req_t dmem_req_q,
  output logic [15:0]                   instr_word,
  output logic                          instr_valid,
  output logic                          instr_skip,
  output logic [7:0]                    dmem_rdata
);
  import data_move_pkg::*;
  logic [17:0] prog [0:63];
  logic [7:0]  mem  [0:4095];
  logic [5:0]  pc_q;
  logic [7:0]  rd_q;
  logic        rv_q;
  initial begin
    rd_q = 8'h00;
    for (int i = 0; i < 64; i++) prog[i] = '0;
  end
  assign instr_valid = prog[pc_q][17];
  assign instr_skip  = prog[pc_q][16];
  // word lines are not held outside the fetch cycle
  assign instr_word  = fetch_q ? prog[pc_q][15:0] : ~prog[pc_q][15:0];
  assign dmem_rdata  = rv_q ? rd_q : ~rd_q;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= 6'h00;
      rv_q <= 1'b0;
    end else begin
      if (fetch_q && instr_valid) pc_q <= pc_q + 6'h01;
      rv_q <= dmem_req_q.rd;
      if (dmem_req_q.rd) rd_q <= mem[dmem_req_q.addr];
      if (dmem_req_q.wr) mem[dmem_req_q.addr] <= dmem_req_q.wdata;
    end
  end
endmodule : prog_data_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the data-move executor.
  Assumes the model stalls on empty program slots.
*/
`timescale 1ns/1ps
module tb_top;
  import data_move_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] instr_word;
  logic instr_valid, instr_skip, fetch_q;
  logic [7:0] dmem_rdata, reg_rdata_q;
  reg_req_t reg_req = '0;
  dmem_req_t dmem_req_q;
  int fails = 0, check_count = 0, wp = 0;
  always #12.5 clk_sys = ~clk_sys;
  data_move_instruction_exec DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_skip(instr_skip), .dmem_rdata(dmem_rdata), .reg_req(reg_req),
    .fetch_q(fetch_q), .dmem_req_q(dmem_req_q), .reg_rdata_q(reg_rdata_q));
  prog_data_model u_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .fetch_q(fetch_q), .dmem_req_q(dmem_req_q),
    .instr_word(instr_word), .instr_valid(instr_valid), .instr_skip(instr_skip), .dmem_rdata(dmem_rdata));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) reg_req <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys) reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) reg_req <= '0;
    #1 chk(reg_rdata_q, exp);
  endtask : reg_rd
  task automatic emit(input logic [15:0] w, input logic skip = 1'b0);
    // scheduled like any other stimulus so the fetch edge never races the load
    u_mem.prog[wp] <= {1'b1, skip, w};
    wp++;
  endtask : emit
  // bounded wait for the model to hand out every word, then let execution finish
  task automatic run;
    int n;
    for (n = 0; n < 200 && u_mem.pc_q != 6'(wp); n++) @(posedge clk_sys);
    if (n == 200) begin
      fails++;
      $display("ERROR %0t fetch stalled", $time);
      conclude();
    end
    repeat (8) @(posedge clk_sys);
  endtask : run
  task automatic t_regs;
    reg_rd(REG_WORK, RST_WORK);
    reg_rd(REG_PTR_LAST, 8'h00);
    reg_wr(4'hb, 8'h55);
    reg_rd(4'hb, 8'h00);
    reg_wr(REG_BANK, 8'hf5);
    reg_rd(REG_BANK, 8'h05);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ptr;
    logic [11:0] k;
    reg_wr(REG_STATUS, 8'h14);
    for (int n = 0; n < 4; n++) begin
      k = 12'h3ab + 12'(n) * 12'h111;
      emit({8'hee, 2'b00, 2'(n), k[11:8]});
      emit({8'hf0, k[7:0]});
    end
    run();
    for (int n = 0; n < 3; n++) begin
      k = 12'h3ab + 12'(n) * 12'h111;
      reg_rd(REG_PTR_BASE + 4'(2 * n), k[7:0]);
      reg_rd(REG_PTR_BASE + 4'(2 * n + 1), {4'h0, k[11:8]});
    end
    reg_rd(REG_STATUS, 8'h14);
    $display("test pointer load done");
  endtask : t_ptr
  task automatic t_move;
    u_mem.mem[12'h5a7] = 8'h80;
    u_mem.mem[12'h500] = 8'h00;
    u_mem.mem[12'h5ff] = 8'h3c;
    emit(16'h51a7);
    run();
    reg_rd(REG_WORK, 8'h80);
    reg_rd(REG_STATUS, 8'h10);
    emit(16'h5300);
    run();
    reg_rd(REG_STATUS, 8'h04);
    emit(16'h53ff);
    run();
    chk(u_mem.mem[12'h5ff], 8'h3c);
    reg_rd(REG_STATUS, 8'h00);
    reg_rd(REG_WORK, 8'h80);
    u_mem.mem[12'hf85] = 8'h42;
    emit(16'h5085);
    run();
    reg_rd(REG_WORK, 8'h42);
    reg_wr(REG_CTRL, 8'h01);
    u_mem.mem[12'h62c] = 8'h99;
    u_mem.mem[12'h060] = 8'h61;
    emit(16'h505f);
    run();
    reg_rd(REG_WORK, 8'h99);
    emit(16'h5060);
    run();
    reg_rd(REG_WORK, 8'h61);
    $display("test move done");
  endtask : t_move
  task automatic t_copy;
    u_mem.mem[12'h123] = 8'h77;
    u_mem.mem[12'h000] = 8'h5a;
    u_mem.mem[12'h789] = 8'h11;
    u_mem.mem[12'h011] = 8'h33;
    reg_wr(REG_STATUS, 8'h14);
    // no destination is a program counter or stack-top byte
    emit(16'hc123);
    emit(16'hf456);
    emit(16'hcff0);
    emit(16'hffff);
    emit(16'hc123);
    emit(16'hf789, 1'b1);
    emit(16'hf011);
    emit(16'hc000);
    emit(16'hfff0);
    run();
    chk(u_mem.mem[12'h456], 8'h77);
    chk(u_mem.mem[12'hfff], 8'h61);
    chk(u_mem.mem[12'h789], 8'h11);
    reg_rd(REG_PTR_BASE + 4'h4, 8'hcd);
    chk(u_mem.mem[12'h011], 8'h33);
    reg_rd(REG_WORK, 8'h5a);
    reg_rd(REG_STATUS, 8'h14);
    $display("test copy done");
  endtask : t_copy
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_ptr();
    t_move();
    t_copy();
    conclude();
  end
endmodule : tb_top
